// [pkg/adcnw_pkg.sv]
// Constants shared by the no-wait read sequencer and its conversion timer.
package adcnw_pkg;
  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int RESULT_W = 12;
  localparam int NIBBLE_W = 4;
  // ****************************************************************
  // Field positions on the data lines
  // ****************************************************************
  localparam int UPPER_MSB = 11;
  localparam int UPPER_LSB = 8;
  localparam int LOW_BYTE_MSB = 7;
  // ****************************************************************
  // Reset and pad values
  // ****************************************************************
  localparam logic [11:0] RESULT_RST = 12'h000;
  localparam logic [3:0] PAD_NIBBLE = 4'h0;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_PS = 4000;
  localparam int CONV_TIME_PS = 2700000;
  // Conversion time is a longest time, so the count rounds down.
  localparam int CONV_CYCLES = (CONV_TIME_PS / CLK_PERIOD_PS < 1) ? 1
                                : CONV_TIME_PS / CLK_PERIOD_PS;
  localparam int CONV_CNT_W = $clog2(CONV_CYCLES + 1);
endpackage

// [pkg/adcnw_conv_if.sv]
// Start, busy and done signals between the sequencer and its conversion timer.
`timescale 1ns/1ns
`default_nettype none
interface adcnw_conv_if;
  logic start;
  logic busy;
  logic done;
  modport timer (input start, output busy, output done);
  modport seq   (output start, input busy, input done);
endinterface
`default_nettype wire

// [verilog/adcnw_conv_timer.sv]
// Conversion timer: runs for a fixed cycle count per start and pulses done.
`timescale 1ns/1ns
`default_nettype none
module adcnw_conv_timer #(
  parameter int CYCLES = adcnw_pkg::CONV_CYCLES
) (
  // Clock and reset
  input  wire logic     core_clk_i,
  input  wire logic     rst_b_i,
  // Conversion control
  adcnw_conv_if.timer   conv
);
  import adcnw_pkg::*;

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_q, cnt_d;
  logic          busy_q, busy_d;
  logic          done_q, done_d;

  // ****************************************************************
  // Counter
  // ****************************************************************
  always_comb begin
    cnt_d  = cnt_q;
    busy_d = busy_q;
    done_d = 1'b0;
    if (!busy_q && conv.start) begin
      busy_d = 1'b1;
      cnt_d  = LOAD;
    end else if (busy_q) begin
      if (cnt_q == '0) begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end else begin
        cnt_d = cnt_q - 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign conv.busy = busy_q;
  assign conv.done = done_q;
endmodule // adcnw_conv_timer
`default_nettype wire

// [verilog/adcnw_read_sequencer.sv]
// No-wait parallel read and conversion-start sequencer of a 12-bit converter.
// Contract
// - Low-byte-select read starts conversion and drives previous full 12-bit result.
// - Next full-width read returns the new result and starts another conversion.
// - Byte hosts use eight low lines; first access behaves like full-width read.
// - High-byte read starts nothing; upper nibble on low four lines, next four low.
// - Third byte read returns low eight bits and starts the next conversion.
// - Upper four result bits always appear on the upper lines when driven.
// - In wait mode busy stalls the first byte access until conversion ends.
// - High-byte access needs no wait states since it starts no conversion.
// - Conversion starts only when select, read and byte select are all low.
// - Start conditions during a running conversion are ignored.
// - Busy stays low for the whole conversion and returns high at its end.
// - Result is right justified, LSB on the lowest data line.
`timescale 1ns/1ns
`default_nettype none
module adcnw_read_sequencer #(
  parameter int CONV_CYC = adcnw_pkg::CONV_CYCLES
) (
  // Clock and reset
  input  wire logic                            core_clk_i,
  input  wire logic                            rst_b_i,
  // Host control pins
  input  wire logic                            select_b_i,
  input  wire logic                            read_b_i,
  input  wire logic                            high_byte_select_i,
  // Code delivered by the converter core at the end of a conversion
  input  wire logic [adcnw_pkg::RESULT_W-1:0]  conv_code_i,
  // Data lines and status
  output logic      [adcnw_pkg::RESULT_W-1:0]  data_o,
  output logic                                 data_oe_o,
  output logic                                 busy_b_o
);
  import adcnw_pkg::*;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [2:0] pin_m_q;
  logic [2:0] pin_s_q;

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_m_q <= 3'h3;
      pin_s_q <= 3'h3;
    end else begin
      pin_m_q <= {high_byte_select_i, read_b_i, select_b_i};
      pin_s_q <= pin_m_q;
    end
  end

  logic sel_b_s;
  logic rd_b_s;
  logic hbs_s;
  assign sel_b_s = pin_s_q[0];
  assign rd_b_s  = pin_s_q[1];
  assign hbs_s   = pin_s_q[2];

  logic acc;
  assign acc = !sel_b_s && !rd_b_s;

  // ****************************************************************
  // Conversion timer
  // ****************************************************************
  adcnw_conv_if conv ();

  adcnw_conv_timer #(
    .CYCLES (CONV_CYC)
  ) u_timer (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .conv       (conv)
  );

  // ****************************************************************
  // Start, busy and result
  // ****************************************************************
  logic                acc_q, acc_d;
  logic                start_q, start_d;
  logic                busy_b_q, busy_b_d;
  logic [RESULT_W-1:0] result_q, result_d;
  logic                start_cond;

  // A start needs a fresh access with all three inputs low and an idle converter.
  assign start_cond = acc && !acc_q && !hbs_s && busy_b_q && !start_q;

  always_comb begin
    acc_d    = acc;
    start_d  = start_cond;
    busy_b_d = busy_b_q;
    result_d = result_q;
    if (start_q) begin
      busy_b_d = 1'b0;
    end else if (conv.done) begin
      busy_b_d = 1'b1;
      result_d = conv_code_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      acc_q    <= 1'b0;
      start_q  <= 1'b0;
      busy_b_q <= 1'b1;
      result_q <= RESULT_RST;
    end else begin
      acc_q    <= acc_d;
      start_q  <= start_d;
      busy_b_q <= busy_b_d;
      result_q <= result_d;
    end
  end

  assign conv.start = start_q;

  // ****************************************************************
  // Data lines
  // ****************************************************************
  logic [RESULT_W-1:0] data_q, data_d;
  logic                oe_q, oe_d;
  logic [NIBBLE_W-1:0] upper;

  // The lines follow the next result, so a held access shows the fresh code
  // in the same cycle in which busy returns high.
  assign upper = result_d[UPPER_MSB:UPPER_LSB];

  always_comb begin
    data_d = '0;
    oe_d   = acc;
    if (acc) begin
      if (hbs_s) begin
        data_d = {upper, PAD_NIBBLE, upper};
      end else begin
        data_d = result_d;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      data_q <= '0;
      oe_q   <= 1'b0;
    end else begin
      data_q <= data_d;
      oe_q   <= oe_d;
    end
  end

  assign data_o    = data_q;
  assign data_oe_o = oe_q;
  assign busy_b_o  = busy_b_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  localparam int A_BUSY_MAX = CONV_CYC + 3;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  a_start_all_low: assert property (
    start_q |-> $past(acc) && !$past(acc_q) && !$past(hbs_s))
    else $error("conversion started without all three inputs low");
  a_no_restart_busy: assert property (
    !busy_b_q |-> !start_q)
    else $error("conversion restarted while busy");
  a_busy_on_start: assert property (
    start_q |=> !busy_b_q [*8])
    else $error("busy did not fall for a conversion");
  a_busy_ends: assert property (
    start_q |-> ##[2:A_BUSY_MAX] $rose(busy_b_q))
    else $error("busy did not return high after a conversion");
  a_low_read_starts: assert property (
    acc && !acc_q && !hbs_s && busy_b_q && !start_q |=> start_q ##1 (conv.busy && !busy_b_q))
    else $error("low byte read failed to start a conversion");
  a_full_word_data: assert property (
    oe_q && !$past(hbs_s) |-> data_q == result_q)
    else $error("full width data mismatch");
  a_high_byte_map: assert property (
    oe_q && $past(hbs_s) |->
      data_q[LOW_BYTE_MSB:0] == {PAD_NIBBLE, result_q[UPPER_MSB:UPPER_LSB]})
    else $error("high byte mapping wrong");
  a_upper_lines: assert property (
    oe_q |-> data_q[UPPER_MSB:UPPER_LSB] == result_q[UPPER_MSB:UPPER_LSB])
    else $error("upper nibble not on upper lines");
  a_high_no_start: assert property (
    acc && hbs_s |=> !start_q)
    else $error("high byte read started a conversion");
  a_release_idle: assert property (
    !$past(acc) |-> !oe_q && data_q == '0)
    else $error("data lines driven outside an access");
  a_result_update: assert property (
    conv.done && !start_q |=> result_q == $past(conv_code_i))
    else $error("result not captured at end of conversion");

  c_start: cover property (start_q);
  c_high_read: cover property (oe_q && $past(hbs_s));
  c_conv_done: cover property (start_q ##[2:A_BUSY_MAX] $rose(busy_b_q));
  c_held_read: cover property (oe_q && $rose(busy_b_q));
endmodule // adcnw_read_sequencer
`default_nettype wire

// [verif/adcnw_host_model.sv]
// Bus master model that issues timed read accesses to the sequencer.
`timescale 1ns/1ns
`default_nettype none
module adcnw_host_model (
  // Clock
  input  wire logic        core_clk_i,
  // Device pins
  output var logic         select_b_o,
  output var logic         read_b_o,
  output var logic         high_byte_select_o,
  input  wire logic [11:0] data_i,
  input  wire logic        data_oe_i,
  input  wire logic        busy_b_i
);
  initial begin
    select_b_o = 1'b1;
    read_b_o = 1'b1;
    high_byte_select_o = 1'b0;
  end

  // One read access; an odd address selects the high byte.
  task automatic access(input logic odd, output logic [11:0] d, output logic bsy);
    @(posedge core_clk_i);
    select_b_o <= 1'b0;
    read_b_o <= 1'b0;
    high_byte_select_o <= odd;
    repeat (5) @(posedge core_clk_i);
    #1;
    d = data_oe_i ? data_i : 12'hzzz;
    bsy = busy_b_i;
    @(posedge core_clk_i);
    select_b_o <= 1'b1;
    read_b_o <= 1'b1;
    // A released address line does not keep its last value.
    high_byte_select_o <= ~odd;
    repeat (4) @(posedge core_clk_i);
  endtask

  // Wait-capable read: holds the access until busy is high, then takes the data.
  task automatic wait_access(input logic odd, output logic [11:0] d, output int waits);
    @(posedge core_clk_i);
    select_b_o <= 1'b0;
    read_b_o <= 1'b0;
    high_byte_select_o <= odd;
    repeat (5) @(posedge core_clk_i);
    #1;
    waits = 0;
    while (busy_b_i !== 1'b1 && waits < 2000) begin
      @(posedge core_clk_i);
      #1;
      waits++;
    end
    d = data_oe_i ? data_i : 12'hzzz;
    @(posedge core_clk_i);
    select_b_o <= 1'b1;
    read_b_o <= 1'b1;
    high_byte_select_o <= ~odd;
    repeat (4) @(posedge core_clk_i);
  endtask
endmodule // adcnw_host_model
`default_nettype wire

// [verif/adcnw_read_sequencer_tb.sv]
// Self-checking bench of the no-wait read sequencer.
`timescale 1ns/1ns
`default_nettype none
module adcnw_read_sequencer_tb;
  import adcnw_pkg::*;
  localparam int CONV = 20;
  localparam int GAP = CONV + 150;
  logic        core_clk_i;
  logic        rst_b_i;
  logic        select_b;
  logic        read_b;
  logic        hbs;
  logic        data_oe;
  logic        busy_b;
  logic        bsy;
  logic [11:0] code;
  logic [11:0] data;
  logic [11:0] got;
  wire  [11:0] data_lines = data_oe ? data : 12'hzzz;
  int          fails;
  int          num_checks;
  int          cyc;
  int          n;
  int          wt;

  adcnw_read_sequencer #(.CONV_CYC(CONV)) DUT (
    .core_clk_i         (core_clk_i),
    .rst_b_i            (rst_b_i),
    .select_b_i         (select_b),
    .read_b_i           (read_b),
    .high_byte_select_i (hbs),
    .conv_code_i        (code),
    .data_o             (data),
    .data_oe_o          (data_oe),
    .busy_b_o           (busy_b)
  );

  adcnw_host_model HOST (
    .core_clk_i         (core_clk_i),
    .select_b_o         (select_b),
    .read_b_o           (read_b),
    .high_byte_select_o (hbs),
    .data_i             (data_lines),
    .data_oe_i          (data_oe),
    .busy_b_i           (busy_b)
  );

  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end

  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      test_done();
    end
  end

  task automatic chk(input logic [11:0] g, input logic [11:0] e);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Read access with the next core code staged; checks data, busy and release.
  task automatic rd(input logic odd, input logic [11:0] nxt, input logic [11:0] e,
                    input logic eb);
    @(posedge core_clk_i);
    code <= nxt;
    HOST.access(odd, got, bsy);
    chk(got, e);
    chk({11'h000, bsy}, {11'h000, eb});
    chk({11'h000, data_oe}, 12'h000);
  endtask

  task automatic wait_idle();
    n = 0;
    while (busy_b !== 1'b1 && n < 100) begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
  endtask

  task automatic t_full();
    rd(1'b0, 12'habc, RESULT_RST, 1'b0);
    wait_idle();
    chk(12'(n >= CONV - 8 && n <= CONV - 2), 12'h001);
    repeat (GAP) @(posedge core_clk_i);
    rd(1'b0, 12'h123, 12'habc, 1'b0);
    wait_idle();
    repeat (GAP) @(posedge core_clk_i);
  endtask

  task automatic t_byte();
    rd(1'b0, 12'h5a7, 12'h123, 1'b0);
    wait_idle();
    repeat (GAP) @(posedge core_clk_i);
    rd(1'b1, 12'h0f0, 12'h505, 1'b1);
    rd(1'b0, 12'h0f0, 12'h5a7, 1'b0);
    wait_idle();
    repeat (GAP) @(posedge core_clk_i);
  endtask

  task automatic t_ignore();
    rd(1'b0, 12'h3c9, 12'h0f0, 1'b0);
    rd(1'b0, 12'h3c9, 12'h0f0, 1'b0);
    wait_idle();
    chk(12'(n <= 8), 12'h001);
    repeat (GAP) @(posedge core_clk_i);
    rd(1'b0, 12'h000, 12'h3c9, 1'b0);
    wait_idle();
  endtask

  task automatic t_wait();
    repeat (GAP) @(posedge core_clk_i);
    code <= 12'h6b4;
    HOST.wait_access(1'b0, got, wt);
    chk(got, 12'h6b4);
    chk(12'(wt), 12'(CONV));
    HOST.wait_access(1'b1, got, wt);
    chk(got, 12'h606);
    chk(12'(wt), 12'h000);
    chk({11'h000, data_oe}, 12'h000);
  endtask

  task automatic t_reset();
    repeat (GAP) @(posedge core_clk_i);
    rd(1'b0, 12'h888, 12'h6b4, 1'b0);
    @(posedge core_clk_i);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    #1;
    chk({10'h000, busy_b, data_oe}, 12'h002);
    @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    rd(1'b0, 12'h999, RESULT_RST, 1'b0);
    wait_idle();
  endtask

  task automatic test_done();
    if (fails == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    rst_b_i = 1'b0;
    code = 12'h000;
    fails = 0;
    num_checks = 0;
    cyc = 0;
    repeat (8) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    t_full();
    t_byte();
    t_ignore();
    t_wait();
    t_reset();
    test_done();
  end
endmodule // adcnw_read_sequencer_tb
`default_nettype wire
